/* shared/tpg_params.svh */
/*
 Constants of the two-port GPIO block: register indices, widths, bit positions,
 reset values and bus response codes.
 Assumes it is included by bare name before any file that uses the names.
*/
`ifndef TPG_PARAMS_SVH
`define TPG_PARAMS_SVH

// Bus widths.
`define TPG_AW 12
`define TPG_DW 32
`define TPG_SW 4

// Register indices; the byte address is four times the index.
`define TPG_IDX_PA 8'h05
`define TPG_IDX_PC 8'h07
`define TPG_IDX_DA 8'h85
`define TPG_IDX_DC 8'h87
`define TPG_IDX_ANA 8'h40
`define TPG_IDX_PEN 8'h41

// Port and field widths.
`define TPG_PA_W 6
`define TPG_PC_W 8
`define TPG_ANA_W 5
`define TPG_PEN_W 3

// Shared pin positions.
`define TPG_PA_T0CK 4
`define TPG_PA_SS 5
`define TPG_PC_T1O 0
`define TPG_PC_T1I 1
`define TPG_PC_CCP 2
`define TPG_PC_SCK 3
`define TPG_PC_SDI 4
`define TPG_PC_SDO 5

// Peripheral enable bits.
`define TPG_EN_T1 0
`define TPG_EN_CCP 1
`define TPG_EN_SER 2

// Byte lane that carries the merge mask of a write.
`define TPG_MASK_LANE 1

// Reset values.
`define TPG_PA_LATCH_RST 6'h00
`define TPG_PC_LATCH_RST 8'h00
`define TPG_DA_RST 6'h3F
`define TPG_DC_RST 8'hFF
`define TPG_ANA_RST 5'h1F
`define TPG_PEN_RST 3'h0

// Bus responses.
`define TPG_RESP_OKAY 2'h0
`define TPG_RESP_SLVERR 2'h2

`endif

/* shared/tpg_pkg.sv */
/*
 Types of the two-port GPIO block: bus carriers, peripheral carriers and the
 state records of its modules.
 Assumes tpg_params.svh is on the include path.
*/
`include "tpg_params.svh"
`default_nettype none

package tpg_pkg;

   typedef struct packed {
      logic [`TPG_AW-1:0] awaddr;
      logic awvalid;
      logic [`TPG_DW-1:0] wdata;
      logic [`TPG_SW-1:0] wstrb;
      logic wvalid;
      logic bready;
      logic [`TPG_AW-1:0] araddr;
      logic arvalid;
      logic rready;
   } tpg_axil_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [`TPG_DW-1:0] rdata;
      logic [1:0] rresp;
   } tpg_axil_rsp_s;

   typedef struct packed {
      logic ccp_out;
      logic sck_out;
      logic sda_out;
      logic sdo_out;
   } tpg_periph_drive_s;

   typedef struct packed {
      logic t0_clk;
      logic ss_n;
      logic t1_clk;
      logic ccp_in;
      logic sck_in;
      logic sdi_in;
   } tpg_periph_sense_s;

   typedef struct packed {
      logic aw_full;
      logic [`TPG_AW-1:0] aw_addr;
      logic w_full;
      logic [`TPG_DW-1:0] w_data;
      logic [`TPG_SW-1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [`TPG_DW-1:0] rdata;
      logic [1:0] rresp;
   } tpg_slv_state_s;

   typedef struct packed {
      logic [`TPG_PA_W-1:0] pa_latch;
      logic [`TPG_PA_W-1:0] pa_dir;
      logic [`TPG_PC_W-1:0] pc_latch;
      logic [`TPG_PC_W-1:0] pc_dir;
      logic [`TPG_ANA_W-1:0] ana;
      logic [`TPG_PEN_W-1:0] pen;
      tpg_periph_sense_s sense;
   } tpg_state_s;

endpackage

`default_nettype wire

/* rtl/tpg_axil_slave.sv */
/*
 AXI4-Lite slave front end: holds write address and data until both are in,
 then issues one write pulse; answers a read in the cycle after it is taken.
 Assumes the register file answers rd_data, rd_ok and wr_ok combinationally.
*/
`include "tpg_params.svh"
`default_nettype none

module tpg_axil_slave (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire tpg_pkg::tpg_axil_req_s axil_req,
   output tpg_pkg::tpg_axil_rsp_s axil_rsp,
   // Register file side
   output logic wr_en,
   output logic [`TPG_AW-1:0] wr_addr,
   output logic [`TPG_DW-1:0] wr_data,
   output logic [`TPG_SW-1:0] wr_strb,
   input wire logic wr_ok,
   output logic rd_en,
   output logic [`TPG_AW-1:0] rd_addr,
   input wire logic [`TPG_DW-1:0] rd_data,
   input wire logic rd_ok
);

   tpg_pkg::tpg_slv_state_s s_reg;
   tpg_pkg::tpg_slv_state_s s_next;

   always_comb begin
      axil_rsp.awready = ~s_reg.aw_full & ~s_reg.bvalid;
      axil_rsp.wready = ~s_reg.w_full & ~s_reg.bvalid;
      axil_rsp.bvalid = s_reg.bvalid;
      axil_rsp.bresp = s_reg.bresp;
      axil_rsp.arready = ~s_reg.rvalid;
      axil_rsp.rvalid = s_reg.rvalid;
      axil_rsp.rdata = s_reg.rdata;
      axil_rsp.rresp = s_reg.rresp;
      wr_en = s_reg.aw_full & s_reg.w_full & ~s_reg.bvalid;
      wr_addr = s_reg.aw_addr;
      wr_data = s_reg.w_data;
      wr_strb = s_reg.w_strb;
      rd_en = axil_req.arvalid & ~s_reg.rvalid;
      rd_addr = axil_req.araddr;
      s_next = s_reg;
      if (axil_req.awvalid && axil_rsp.awready) begin
         s_next.aw_full = 1'b1;
         s_next.aw_addr = axil_req.awaddr;
      end
      if (axil_req.wvalid && axil_rsp.wready) begin
         s_next.w_full = 1'b1;
         s_next.w_data = axil_req.wdata;
         s_next.w_strb = axil_req.wstrb;
      end
      if (wr_en) begin
         s_next.aw_full = 1'b0;
         s_next.w_full = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = wr_ok ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
      end
      if (s_reg.bvalid && axil_req.bready) begin
         s_next.bvalid = 1'b0;
      end
      if (rd_en) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_ok ? rd_data : '0;
         s_next.rresp = rd_ok ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
      end
      if (s_reg.rvalid && axil_req.rready) begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule

`default_nettype wire

/* rtl/tpg_pin_mux.sv */
/*
 Pin multiplexer of ports A and C: chooses between latch and peripheral drive,
 applies direction and overrides, and masks digital reads of analog pins.
 Assumes pin inputs are already synchronous to the system clock.
*/
`include "tpg_params.svh"
`default_nettype none

module tpg_pin_mux (
   // Port state
   input wire logic [`TPG_PA_W-1:0] pa_latch,
   input wire logic [`TPG_PA_W-1:0] pa_dir,
   input wire logic [`TPG_PC_W-1:0] pc_latch,
   input wire logic [`TPG_PC_W-1:0] pc_dir,
   input wire logic [`TPG_ANA_W-1:0] ana,
   input wire logic [`TPG_PEN_W-1:0] pen,
   // Peripheral drive
   input wire tpg_pkg::tpg_periph_drive_s drive,
   // Pins
   input wire logic [`TPG_PA_W-1:0] pa_in,
   output logic [`TPG_PA_W-1:0] pa_out,
   output logic [`TPG_PA_W-1:0] pa_oe,
   input wire logic [`TPG_PC_W-1:0] pc_in,
   output logic [`TPG_PC_W-1:0] pc_out,
   output logic [`TPG_PC_W-1:0] pc_oe,
   // Digital read values
   output logic [`TPG_PA_W-1:0] pa_rd,
   output logic [`TPG_PC_W-1:0] pc_rd
);

   logic [`TPG_PA_W-1:0] ana_map;

   always_comb begin
      // Bit 4 has no analog function, so it never reads as analog.
      ana_map = {ana[`TPG_ANA_W-1], 1'b0, ana[`TPG_ANA_W-2:0]}; // R8
      pa_out = pa_latch; // R3
      pa_oe = ~pa_dir; // R1 R2 R10
      pa_out[`TPG_PA_T0CK] = 1'b0; // R6
      pa_oe[`TPG_PA_T0CK] = ~pa_dir[`TPG_PA_T0CK] & ~pa_latch[`TPG_PA_T0CK]; // R16
      if (pen[`TPG_EN_SER]) begin
         pa_oe[`TPG_PA_SS] = 1'b0; // R7 R11
      end
      pa_rd = pa_in & ~ana_map; // R4 R9
      pc_out = pc_latch;
      pc_oe = ~pc_dir;
      if (pen[`TPG_EN_T1]) begin
         pc_oe[`TPG_PC_T1O] = 1'b0; // R12 R11
         pc_oe[`TPG_PC_T1I] = 1'b0; // R12
      end
      if (pen[`TPG_EN_CCP]) begin
         pc_out[`TPG_PC_CCP] = drive.ccp_out; // R13 R11
      end
      if (pen[`TPG_EN_SER]) begin
         pc_out[`TPG_PC_SCK] = drive.sck_out; // R14 R11
         pc_out[`TPG_PC_SDI] = drive.sda_out; // R14
         pc_out[`TPG_PC_SDO] = drive.sdo_out; // R14
      end
      pc_rd = pc_in; // R4
   end

endmodule

`default_nettype wire

/* rtl/tpg_gpio.sv */
/*
 Two-port GPIO top: register file for ports A and C behind an AXI4-Lite
 slave, pin sharing with timer, capture/compare, analog and serial functions.
 Assumes the pad ring resolves pin levels from out and oe, and that the
 peripherals drive their pin outputs synchronously to aclk.
*/
// The AXI4-Lite register port was decided locally.
`include "tpg_params.svh"
`default_nettype none

// Overview of operation
// R1 - Port A is six bidirectional pins
// R2 - Direction one floats the port A pin
// R3 - Direction zero drives the latch value
// R4 - Data reads pins, writes load latch
// R5 - Writes merge sampled pins into latch
// R6 - A4 timer clock input, open drain
// R7 - A5 doubles as serial slave select
// R8 - Analog config picks analog or digital
// R9 - Analog pins reset analog, read zero
// R10 - Direction bits still govern analog pins
// R11 - Enabled peripheral owns its shared pin
// R12 - Timer1 pins C0, C1 override direction
// R13 - C2 capture/compare keeps its direction
// R14 - C3-C5 serial pins keep their direction
// R15 - Power reset clears all; others keep latch
// R16 - A4 pulls low only when driven zero
module tpg_gpio (
   // Clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic soft_resetn,
   // Register bus
   input wire tpg_pkg::tpg_axil_req_s axil_req,
   output tpg_pkg::tpg_axil_rsp_s axil_rsp,
   // Port A pins
   input wire logic [`TPG_PA_W-1:0] pa_in,
   output logic [`TPG_PA_W-1:0] pa_out,
   output logic [`TPG_PA_W-1:0] pa_oe,
   // Port C pins
   input wire logic [`TPG_PC_W-1:0] pc_in,
   output logic [`TPG_PC_W-1:0] pc_out,
   output logic [`TPG_PC_W-1:0] pc_oe,
   // Peripherals
   input wire tpg_pkg::tpg_periph_drive_s periph_drive,
   output tpg_pkg::tpg_periph_sense_s periph_sense
);

   localparam tpg_pkg::tpg_state_s ST_RST = '{
      pa_latch: `TPG_PA_LATCH_RST,
      pa_dir: `TPG_DA_RST,
      pc_latch: `TPG_PC_LATCH_RST,
      pc_dir: `TPG_DC_RST,
      ana: `TPG_ANA_RST,
      pen: `TPG_PEN_RST,
      sense: '0
   };

   tpg_pkg::tpg_state_s s_reg;
   tpg_pkg::tpg_state_s s_next;

   logic wr_en;
   logic [`TPG_AW-1:0] wr_addr;
   logic [`TPG_DW-1:0] wr_data;
   logic [`TPG_SW-1:0] wr_strb;
   logic wr_ok;
   logic rd_en;
   logic [`TPG_AW-1:0] rd_addr;
   logic [`TPG_DW-1:0] rd_data;
   logic rd_ok;
   logic [`TPG_PA_W-1:0] pa_rd;
   logic [`TPG_PC_W-1:0] pc_rd;
   logic use_mask;
   logic [`TPG_PC_W-1:0] wmask;
   logic [`TPG_PC_W-1:0] pa_wide;

   // True when a byte address hits the given register index.
   function automatic logic reg_hit(input logic [`TPG_AW-1:0] addr, input logic [7:0] idx);
      reg_hit = (addr[`TPG_AW-1:2] == {2'h0, idx});
   endfunction

   function automatic logic reg_mapped(input logic [`TPG_AW-1:0] addr);
      reg_mapped = reg_hit(addr, `TPG_IDX_PA) | reg_hit(addr, `TPG_IDX_PC) |
                   reg_hit(addr, `TPG_IDX_DA) | reg_hit(addr, `TPG_IDX_DC) |
                   reg_hit(addr, `TPG_IDX_ANA) | reg_hit(addr, `TPG_IDX_PEN);
   endfunction

   // Masked bits take the new value, the rest take the level sampled on the pin.
   // Without a mask every bit is written, which equals a full-byte merge.
   function automatic logic [`TPG_PC_W-1:0] rmw_merge(input logic [`TPG_PC_W-1:0] pins,
                                                      input logic [`TPG_PC_W-1:0] data,
                                                      input logic [`TPG_PC_W-1:0] mask);
      rmw_merge = (data & mask) | (pins & ~mask);
   endfunction

   tpg_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .axil_req(axil_req),
      .axil_rsp(axil_rsp),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   tpg_pin_mux u_mux (
      .pa_latch(s_reg.pa_latch),
      .pa_dir(s_reg.pa_dir),
      .pc_latch(s_reg.pc_latch),
      .pc_dir(s_reg.pc_dir),
      .ana(s_reg.ana),
      .pen(s_reg.pen),
      .drive(periph_drive),
      .pa_in(pa_in),
      .pa_out(pa_out),
      .pa_oe(pa_oe),
      .pc_in(pc_in),
      .pc_out(pc_out),
      .pc_oe(pc_oe),
      .pa_rd(pa_rd),
      .pc_rd(pc_rd)
   );

   assign periph_sense = s_reg.sense;

   always_comb begin
      wr_ok = reg_mapped(wr_addr);
      rd_ok = reg_mapped(rd_addr);
      rd_data = '0;
      if (reg_hit(rd_addr, `TPG_IDX_PA)) begin
         rd_data[`TPG_PA_W-1:0] = pa_rd; // R4
      end else if (reg_hit(rd_addr, `TPG_IDX_PC)) begin
         rd_data[`TPG_PC_W-1:0] = pc_rd; // R4
      end else if (reg_hit(rd_addr, `TPG_IDX_DA)) begin
         rd_data[`TPG_PA_W-1:0] = s_reg.pa_dir;
      end else if (reg_hit(rd_addr, `TPG_IDX_DC)) begin
         rd_data[`TPG_PC_W-1:0] = s_reg.pc_dir;
      end else if (reg_hit(rd_addr, `TPG_IDX_ANA)) begin
         rd_data[`TPG_ANA_W-1:0] = s_reg.ana;
      end else if (reg_hit(rd_addr, `TPG_IDX_PEN)) begin
         rd_data[`TPG_PEN_W-1:0] = s_reg.pen;
      end
   end

   always_comb begin
      use_mask = wr_strb[`TPG_MASK_LANE];
      wmask = use_mask ? wr_data[2*`TPG_PC_W-1:`TPG_PC_W] : '1;
      pa_wide = rmw_merge({2'h0, pa_rd}, wr_data[`TPG_PC_W-1:0], wmask);
      s_next = s_reg;
      // Peripherals see raw pin levels; analog masking only hides digital reads.
      s_next.sense.t0_clk = pa_in[`TPG_PA_T0CK]; // R6
      s_next.sense.ss_n = pa_in[`TPG_PA_SS]; // R7
      s_next.sense.t1_clk = pc_in[`TPG_PC_T1O]; // R12
      s_next.sense.ccp_in = pc_in[`TPG_PC_CCP]; // R13
      s_next.sense.sck_in = pc_in[`TPG_PC_SCK]; // R14
      s_next.sense.sdi_in = pc_in[`TPG_PC_SDI]; // R14
      if (wr_en && wr_strb[0]) begin
         if (reg_hit(wr_addr, `TPG_IDX_PA)) begin
            // Port A is narrower than the merge, so only its own bits are kept.
            s_next.pa_latch = pa_wide[`TPG_PA_W-1:0]; // R4 R5
         end
         if (reg_hit(wr_addr, `TPG_IDX_PC)) begin
            s_next.pc_latch = rmw_merge(pc_rd, wr_data[`TPG_PC_W-1:0], wmask); // R4 R5
         end
         if (reg_hit(wr_addr, `TPG_IDX_DA)) begin
            s_next.pa_dir = wr_data[`TPG_PA_W-1:0]; // R1
         end
         if (reg_hit(wr_addr, `TPG_IDX_DC)) begin
            s_next.pc_dir = wr_data[`TPG_PC_W-1:0];
         end
         if (reg_hit(wr_addr, `TPG_IDX_ANA)) begin
            s_next.ana = wr_data[`TPG_ANA_W-1:0]; // R8
         end
         if (reg_hit(wr_addr, `TPG_IDX_PEN)) begin
            s_next.pen = wr_data[`TPG_PEN_W-1:0]; // R11
         end
      end
      // A warm reset restores configuration but leaves both latches alone.
      if (!soft_resetn) begin
         s_next.pa_dir = `TPG_DA_RST; // R15
         s_next.pc_dir = `TPG_DC_RST; // R15
         s_next.ana = `TPG_ANA_RST; // R9
         s_next.pen = `TPG_PEN_RST;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= ST_RST; // R15 R9
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence seq_pc_write;
      wr_en && wr_strb[0] && reg_hit(wr_addr, `TPG_IDX_PC);
   endsequence

   sequence seq_pa_read;
      rd_en && reg_hit(rd_addr, `TPG_IDX_PA);
   endsequence

   sequence seq_warm_reset;
      !soft_resetn && !wr_en;
   endsequence

   sequence seq_write_taken;
      axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
   endsequence

   sequence seq_da_write;
      wr_en && wr_strb[0] && reg_hit(wr_addr, `TPG_IDX_DA) && soft_resetn;
   endsequence

   chk_pa_input_float: assert property ( // R2
      (pa_oe & s_reg.pa_dir) == '0)
      else $error("Port A pin driven while its direction is input.");

   chk_pa_drive_latch: assert property ( // R3
      (!s_reg.pa_dir[0] |-> pa_oe[0] && pa_out[0] == s_reg.pa_latch[0]) and
      (!s_reg.pa_dir[3] && s_reg.ana[3] |-> pa_oe[3] && pa_out[3] == s_reg.pa_latch[3]))
      else $error("Port A output pin does not drive its latch.");

   chk_pa_read_pins: assert property ( // R4
      seq_pa_read |=> axil_rsp.rvalid && axil_rsp.rdata[`TPG_PA_W-1:0] == $past(pa_rd))
      else $error("Port A read did not return the pin levels.");

   chk_pc_rmw_merge: assert property ( // R5
      seq_pc_write |=> s_reg.pc_latch == (($past(wr_data[`TPG_PC_W-1:0]) & $past(wmask)) |
                                          ($past(pc_in) & ~$past(wmask))))
      else $error("Port C latch is not the merge of pins and write data.");

   chk_od_bit4_drive: assert property ( // R16
      pa_out[`TPG_PA_T0CK] == 1'b0 &&
      pa_oe[`TPG_PA_T0CK] == (!s_reg.pa_dir[`TPG_PA_T0CK] && !s_reg.pa_latch[`TPG_PA_T0CK]))
      else $error("Open-drain pin drives high or at the wrong time.");

   chk_t0_clock_sense: assert property ( // R6
      ##1 periph_sense.t0_clk == $past(pa_in[`TPG_PA_T0CK]))
      else $error("Timer clock input does not follow its pin.");

   chk_ss_owned: assert property ( // R7
      s_reg.pen[`TPG_EN_SER] |-> !pa_oe[`TPG_PA_SS])
      else $error("Slave select pin driven while the serial port owns it.");

   chk_analog_read_zero: assert property ( // R9
      s_reg.ana[0] |-> pa_rd[0] == 1'b0 && pa_oe[0] == !s_reg.pa_dir[0])
      else $error("Analog pin reads nonzero or ignores its direction.");

   chk_t1_override: assert property ( // R12
      s_reg.pen[`TPG_EN_T1] |-> pc_oe[`TPG_PC_T1I:`TPG_PC_T1O] == 2'h0)
      else $error("Timer1 pins driven while the oscillator owns them.");

   chk_ccp_direction: assert property ( // R13
      s_reg.pen[`TPG_EN_CCP] |->
         pc_oe[`TPG_PC_CCP] == !s_reg.pc_dir[`TPG_PC_CCP] &&
         pc_out[`TPG_PC_CCP] == periph_drive.ccp_out)
      else $error("Capture/compare pin direction or drive is wrong.");

   chk_serial_direction: assert property ( // R14
      s_reg.pen[`TPG_EN_SER] |->
         pc_oe[`TPG_PC_SDO:`TPG_PC_SCK] == ~s_reg.pc_dir[`TPG_PC_SDO:`TPG_PC_SCK] &&
         pc_out[`TPG_PC_SDO] == periph_drive.sdo_out)
      else $error("Serial pins direction overridden or drive wrong.");

   chk_warm_keeps_latch: assert property ( // R15
      seq_warm_reset |=> s_reg.pc_latch == $past(s_reg.pc_latch) &&
                         s_reg.pc_dir == `TPG_DC_RST && s_reg.pa_dir == `TPG_DA_RST)
      else $error("Warm reset lost the latch or kept the direction.");

   chk_write_answer: assert property (
      seq_write_taken ##1 !axil_rsp.bvalid |=> axil_rsp.bvalid)
      else $error("Write response not given one cycle after the pulse.");

   chk_pa_dir_write: assert property ( // R1
      seq_da_write |=> s_reg.pa_dir == $past(wr_data[`TPG_PA_W-1:0]))
      else $error("Port A direction write did not land.");

   chk_analog_digital: assert property ( // R8
      pa_rd[`TPG_PA_SS] == (pa_in[`TPG_PA_SS] && !s_reg.ana[`TPG_ANA_W-1]) &&
      pa_rd[`TPG_PA_T0CK] == pa_in[`TPG_PA_T0CK])
      else $error("Analog selection does not gate the digital read.");

   chk_analog_dir_kept: assert property ( // R10
      s_reg.ana[1] |-> pa_oe[1] == !s_reg.pa_dir[1] && pa_out[1] == s_reg.pa_latch[1])
      else $error("Analog pin no longer follows its direction bit.");

   chk_serial_release: assert property ( // R11
      !s_reg.pen[`TPG_EN_SER] |->
         pc_out[`TPG_PC_SDO:`TPG_PC_SCK] == s_reg.pc_latch[`TPG_PC_SDO:`TPG_PC_SCK] &&
         pa_oe[`TPG_PA_SS] == !s_reg.pa_dir[`TPG_PA_SS])
      else $error("Serial pins not returned to port use when disabled.");

   // The power reset is checked while it is active, so the default disable is lifted.
   chk_power_reset: assert property ( // R15
      disable iff (1'b0)
      !aresetn |=> s_reg.pc_dir == `TPG_DC_RST && s_reg.pa_dir == `TPG_DA_RST &&
                   s_reg.ana == `TPG_ANA_RST && s_reg.pen == `TPG_PEN_RST)
      else $error("Power reset did not restore the configuration.");

endmodule

`default_nettype wire

/* test/tpg_pin_model.sv */
/*
 Model of the circuitry outside ports A and C: each pin shows the block's
 drive where its enable is high and the bench's outside level elsewhere.
 Assumes the bench supplies one outside level vector per port.
*/
`default_nettype none

module tpg_pin_model (
   // Block side
   input wire logic [5:0] pa_out,
   input wire logic [5:0] pa_oe,
   input wire logic [7:0] pc_out,
   input wire logic [7:0] pc_oe,
   // Outside levels
   input wire logic [5:0] ext_pa,
   input wire logic [7:0] ext_pc,
   // Resolved pins
   output logic [5:0] pa_in,
   output logic [7:0] pc_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // The block wins where it drives; a real board would contend, and the bench drives port A against outside levels, relying on the block winning.
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_pa);
   assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_pc);
endmodule

`default_nettype wire

/* test/tpg_gpio_tb.sv */
/*
 Self-checking bench of the two-port GPIO block: register access over
 AXI4-Lite, pin drive, read-modify-write, pin sharing and both resets.
 Assumes tpg_params.svh on the include path and the pin model beside it.
*/
`include "tpg_params.svh"
`default_nettype none

module tpg_gpio_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, soft_resetn;
   tpg_pkg::tpg_axil_req_s req;
   tpg_pkg::tpg_axil_rsp_s rsp;
   tpg_pkg::tpg_periph_drive_s drv;
   tpg_pkg::tpg_periph_sense_s sns;
   logic [5:0] pa_in, pa_out, pa_oe, ext_pa, v, m, e, x;
   logic [7:0] pc_in, pc_out, pc_oe, ext_pc, d, eo;
   logic [3:0] dv;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   int n_mismatch = 0;
   int n_tests = 0;

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   tpg_gpio tpg_gpio_i (.aclk(aclk), .aresetn(aresetn), .soft_resetn(soft_resetn),
      .axil_req(req), .axil_rsp(rsp), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
      .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .periph_drive(drv),
      .periph_sense(sns));

   tpg_pin_model tpg_pin_model_i (.pa_out(pa_out), .pa_oe(pa_oe), .pc_out(pc_out),
      .pc_oe(pc_oe), .ext_pa(ext_pa), .ext_pc(ext_pc), .pa_in(pa_in), .pc_in(pc_in));

   task automatic chk(input string n, input logic [33:0] xp, input logic [33:0] s);
      n_tests++;
      if (s !== xp) begin
         $display("[ERR] %s expected %h seen %h", n, xp, s);
         n_mismatch++;
      end
   endtask

   task automatic done(input string n);
      $display("test %s done", n);
   endtask

   // Ready lines stay high after reset, so a response is taken at the edge it shows.
   task automatic axw(input logic [7:0] i, input logic [31:0] dt, input logic [3:0] s,
                      input logic [1:0] er);
      logic b;
      bq.push_back(er);
      req.awaddr <= {2'b00, i, 2'b00};
      req.wdata <= dt;
      req.wstrb <= s;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) b = 1'b1;
      end
   endtask

   task automatic axr(input logic [7:0] i, input logic [31:0] xp, input logic [1:0] er);
      logic r;
      rq.push_back({er, xp});
      req.araddr <= {2'b00, i, 2'b00};
      req.arvalid <= 1'b1;
      r = 1'b0;
      while (!r) begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) r = 1'b1;
      end
   endtask

   task automatic wr(input logic [7:0] i, input logic [31:0] dt);
      axw(i, dt, 4'h1, `TPG_RESP_OKAY);
   endtask

   task automatic rd(input logic [7:0] i, input logic [31:0] xp);
      axr(i, xp, `TPG_RESP_OKAY);
   endtask

   always @(posedge aclk) begin
      if (rsp.bvalid && req.bready) chk("bresp", bq.pop_front(), rsp.bresp);
      if (rsp.rvalid && req.rready) chk("rdata", rq.pop_front(), {rsp.rresp, rsp.rdata});
   end

   task automatic results;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge aclk);
      n_mismatch++;
      results();
   end

   initial begin
      req = '0;
      aresetn = 1'b0;
      soft_resetn = 1'b1;
      ext_pa = 6'h00;
      ext_pc = 8'h00;
      drv = '0;
      void'($urandom(28097));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      req.bready <= 1'b1;
      req.rready <= 1'b1;
      ext_pa <= 6'h3F;
      ext_pc <= 8'h96;
      @(posedge aclk);
      chk("pa_oe", 6'h00, pa_oe);
      chk("pc_oe", 8'h00, pc_oe);
      rd(`TPG_IDX_DA, 32'h3F);
      rd(`TPG_IDX_DC, 32'hFF);
      rd(`TPG_IDX_PA, 32'h10);
      rd(`TPG_IDX_PC, 32'h96);
      done("reset");
      ext_pa <= 6'h00;
      wr(`TPG_IDX_ANA, 32'h00);
      wr(`TPG_IDX_DA, 32'h00);
      wr(`TPG_IDX_PA, 32'h2A);
      chk("pa_oe", 6'h3F, pa_oe);
      chk("pa_out", 6'h2A, pa_out);
      wr(`TPG_IDX_PA, 32'h3F);
      chk("pa_oe", 6'h2F, pa_oe);
      rd(`TPG_IDX_PA, 32'h2F);
      wr(`TPG_IDX_ANA, 32'h1F);
      chk("pa_oe", 6'h2F, pa_oe);
      rd(`TPG_IDX_PA, 32'h00);
      wr(`TPG_IDX_ANA, 32'h00);
      done("drive");
      wr(`TPG_IDX_DA, 32'h3F);
      repeat (4) begin
         x = 6'($urandom);
         v = 6'($urandom);
         m = 6'($urandom);
         ext_pa <= x;
         e = (v & m) | (x & ~m);
         axw(`TPG_IDX_PA, {16'h0, 2'b00, m, 2'b00, v}, 4'h3, `TPG_RESP_OKAY);
         wr(`TPG_IDX_DA, 32'h00);
         chk("pa_out", e & 6'h2F, pa_out & 6'h2F);
         chk("pa_oe", {1'b1, ~e[4], 4'hF}, pa_oe);
         wr(`TPG_IDX_DA, 32'h3F);
         chk("pa_oe", 6'h00, pa_oe);
      end
      done("merge");
      d = 8'($urandom);
      wr(`TPG_IDX_DC, {24'h0, d});
      wr(`TPG_IDX_PC, 32'hC3);
      wr(`TPG_IDX_DA, 32'h00);
      for (int p = 0; p < 8; p++) begin
         dv = 4'($urandom);
         drv <= dv;
         wr(`TPG_IDX_PEN, p);
         eo = 8'hC3;
         if (p[1]) eo[2] = dv[3];
         if (p[2]) eo[5:3] = {dv[0], dv[1], dv[2]};
         chk("pc_oe", ~d & (p[0] ? 8'hFC : 8'hFF), pc_oe);
         chk("pc_out", eo[7:2], pc_out[7:2]);
         chk("pa_oe5", !p[2], pa_oe[5]);
      end
      done("sharing");
      wr(`TPG_IDX_PEN, 32'h0);
      wr(`TPG_IDX_DC, 32'hFF);
      wr(`TPG_IDX_DA, 32'h3F);
      repeat (3) begin
         x = 6'($urandom);
         d = 8'($urandom);
         ext_pa <= x;
         ext_pc <= d;
         repeat (2) @(posedge aclk);
         chk("sense", {x[4], x[5], d[0], d[2], d[3], d[4]}, sns);
         rd(`TPG_IDX_PC, {24'h0, d});
      end
      done("sense");
      axw(8'h10, 32'hFF, 4'h1, `TPG_RESP_SLVERR);
      axr(8'h10, 32'h0, `TPG_RESP_SLVERR);
      rd(`TPG_IDX_DA, 32'h3F);
      done("unmapped");
      wr(`TPG_IDX_PC, 32'h5A);
      wr(`TPG_IDX_DC, 32'h00);
      soft_resetn <= 1'b0;
      @(posedge aclk);
      soft_resetn <= 1'b1;
      rd(`TPG_IDX_DC, 32'hFF);
      chk("pc_oe", 8'h00, pc_oe);
      wr(`TPG_IDX_DC, 32'h00);
      chk("pc_out", 8'h5A, pc_out);
      done("warm reset");
      results();
   end
endmodule

`default_nettype wire
